// ==== hw/acts_top.sv ====
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module acts_top
    import acts_pkg::*;
#(
    parameter int P_STEP_US = STEP_US
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // axi4-lite write channels
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read channels
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // converter engine
    output logic o_conv_start,
    input wire logic i_conv_done,
    input wire logic [9:0] i_conv_data,
    // trigger pin and host signals
    input wire logic i_trigger_pin,
    output logic o_int_n,
    output logic o_busy
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (P_STEP_US < 1 || P_STEP_US > 255) begin : g_chk
        $error("timing step must be 1 to 255 us");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte-lane merge for register writes
    function automatic logic [31:0] acts_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb,
        input logic [31:0] wmask
    );
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old_v & ~m) | (new_v & m);
    endfunction : acts_merge

    // samples per cycle: 1, 4, 8 .. 256
    function automatic logic [8:0] acts_nsamp(input logic [2:0] code);
        // shift amount widened so code 7 gives 256, not a wrap to 1
        return (code == 3'h0) ? 9'h001 : 9'(9'h001 << ({1'b0, code} + 4'h1));
    endfunction : acts_nsamp

    // average = sum shifted by log2 of count
    function automatic logic [10:0] acts_avg(
        input logic [17:0] s,
        input logic [2:0] code
    );
        logic [17:0] t;
        t = s >> ((code == 3'h0) ? 4'h0 : ({1'b0, code} + 4'h1));
        return t[10:0];
    endfunction : acts_avg

    // us steps from a 4-bit code
    function automatic logic [11:0] acts_us(input logic [3:0] code);
        return 12'(code * P_STEP_US);
    endfunction : acts_us

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff; // control word
    logic [31:0] time_ff; // delay and wait codes
    logic [31:0] lim_ff; // low and high limits
    logic en_prev_ff; // enable edge finder
    logic [10:0] res_ff [4]; // result registers by select
    logic aw_rdy_ff, w_rdy_ff, aw_have_ff, w_have_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff, ar_rdy_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic trig_s1_ff, trig_s2_ff, trig_prev_ff; // pin sync
    acts_state_t state_ff;
    logic [2:0] cfg_cnt_ff; // latched sample count code
    logic cfg_ext_ff, cfg_edge_ff, cfg_hold_ff;
    logic [3:0] cfg_wait_ff, cfg_dly_ff;
    logic [9:0] cfg_lo_ff, cfg_hi_ff;
    logic [8:0] cnt_ff; // samples taken
    logic [11:0] tmr_ff; // microseconds left
    logic [7:0] pre_ff; // prescaler
    logic seen_ff; // edge seen during wait
    logic abort_ff; // limit hit
    logic busy_ff, done_ff, int_n_ff, conv_start_ff;
    logic [9:0] min_ff, max_ff, last_ff;
    logic [17:0] sum_ff;
    logic wr_go, en_rise, edge_hit, trig_act;
    logic out_lim, rep_go, cyc_start;

    // ------------------------------------------------------------
    // combinational decode
    // ------------------------------------------------------------
    assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
    assign en_rise = ctrl_ff[CTRL_EN] && !en_prev_ff;
    // matching edge on the synced pin
    assign edge_hit = cfg_edge_ff ? (trig_s2_ff && !trig_prev_ff)
                                  : (!trig_s2_ff && trig_prev_ff);
    // active level follows the chosen edge
    assign trig_act = cfg_edge_ff ? trig_s2_ff : !trig_s2_ff;
    assign out_lim = (i_conv_data > cfg_hi_ff) || (i_conv_data < cfg_lo_ff);
    // repeat bit is read live so clearing it ends the run
    assign rep_go = ctrl_ff[CTRL_REP] && !abort_ff;
    assign cyc_start = (state_ff == S_IDLE && en_rise) ||
                       (state_ff == S_FIN && rep_go);

    // ------------------------------------------------------------
    // axi write path
    // ------------------------------------------------------------
    // address and data taken in either order
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_rdy_ff <= 1'b1;
            w_rdy_ff <= 1'b1;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            if (i_awvalid && aw_rdy_ff) begin
                aw_addr_ff <= i_awaddr;
                aw_have_ff <= 1'b1;
                aw_rdy_ff <= 1'b0;
            end
            if (i_wvalid && w_rdy_ff) begin
                w_data_ff <= i_wdata;
                w_strb_ff <= i_wstrb;
                w_have_ff <= 1'b1;
                w_rdy_ff <= 1'b0;
            end
            if (wr_go) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                // unmapped or read-only word answers slverr
                bresp_ff <= (aw_addr_ff == REG_CTRL || aw_addr_ff == REG_TIME ||
                             aw_addr_ff == REG_LIMIT) ? RESP_OKAY : RESP_SLVERR;
            end
            // both readies reopen once the answer is taken
            if (bvalid_ff && i_bready) begin
                bvalid_ff <= 1'b0;
                aw_rdy_ff <= 1'b1;
                w_rdy_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_ff <= CTRL_RST;
            time_ff <= TIME_RST;
            lim_ff <= LIMIT_RST;
        end else if (wr_go) begin
            case (aw_addr_ff)
                REG_CTRL: begin
                    ctrl_ff <= acts_merge(ctrl_ff, w_data_ff, w_strb_ff, CTRL_WMASK);
                    // select bits frozen while a cycle runs
                    if (busy_ff) begin
                        ctrl_ff[CTRL_SEL+1:CTRL_SEL] <= ctrl_ff[CTRL_SEL+1:CTRL_SEL];
                    end
                end
                REG_TIME: time_ff <= acts_merge(time_ff, w_data_ff, w_strb_ff, TIME_WMASK);
                REG_LIMIT: lim_ff <= acts_merge(lim_ff, w_data_ff, w_strb_ff, LIMIT_WMASK);
                default: ; // writes elsewhere are dropped
            endcase
        end
    end

    // ------------------------------------------------------------
    // axi read path
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ar_rdy_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (i_arvalid && ar_rdy_ff) begin
            ar_rdy_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (i_araddr)
                REG_CTRL: rdata_ff <= ctrl_ff;
                REG_TIME: rdata_ff <= time_ff;
                REG_LIMIT: rdata_ff <= lim_ff;
                // selected result with busy flag
                REG_RESULT: rdata_ff <= {16'h0000, busy_ff, 4'h0,
                    res_ff[ctrl_ff[CTRL_SEL+1:CTRL_SEL]]};
                REG_STATUS: rdata_ff <= {28'h0000_000, state_ff == S_ARM,
                    abort_ff, done_ff, busy_ff};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && i_rready) begin
            rvalid_ff <= 1'b0;
            ar_rdy_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // trigger pin synchroniser
    // ------------------------------------------------------------
    // pin is asynchronous; first stage read only by second
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trig_s1_ff <= 1'b0;
            trig_s2_ff <= 1'b0;
            trig_prev_ff <= 1'b0;
        end else begin
            trig_s1_ff <= i_trigger_pin;
            trig_s2_ff <= trig_s1_ff;
            trig_prev_ff <= trig_s2_ff;
        end
    end

    // enable edge tracker
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            en_prev_ff <= 1'b0;
        end else begin
            en_prev_ff <= ctrl_ff[CTRL_EN];
        end
    end

    // ------------------------------------------------------------
    // configuration latch
    // ------------------------------------------------------------
    // software may rewrite registers mid-cycle; the run
    // keeps what it saw at its start
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_cnt_ff <= 3'h0;
            cfg_ext_ff <= 1'b0;
            cfg_edge_ff <= 1'b0;
            cfg_hold_ff <= 1'b0;
            cfg_dly_ff <= 4'h0;
            cfg_wait_ff <= 4'h0;
            cfg_lo_ff <= 10'h000;
            cfg_hi_ff <= 10'h3FF;
        end else if (state_ff == S_IDLE && en_rise) begin
            cfg_cnt_ff <= ctrl_ff[CTRL_CNT+2:CTRL_CNT];
            cfg_ext_ff <= ctrl_ff[CTRL_EXT];
            cfg_edge_ff <= ctrl_ff[CTRL_EDGE];
            cfg_hold_ff <= ctrl_ff[CTRL_HOLD];
            cfg_dly_ff <= time_ff[TIME_DLY+3:TIME_DLY];
            cfg_wait_ff <= time_ff[TIME_WAIT+3:TIME_WAIT];
            cfg_lo_ff <= lim_ff[LIM_LO+9:LIM_LO];
            cfg_hi_ff <= lim_ff[LIM_HI+9:LIM_HI];
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // owns the timer so load and count never fight
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= S_IDLE;
            tmr_ff <= 12'h000;
            pre_ff <= 8'h00;
            cnt_ff <= 9'h000;
            seen_ff <= 1'b0;
            abort_ff <= 1'b0;
            conv_start_ff <= 1'b0;
        end else begin
            conv_start_ff <= 1'b0;
            // prescaled microsecond countdown
            if (tmr_ff != 12'h000) begin
                if (pre_ff == 8'(US_CYC - 1)) begin
                    pre_ff <= 8'h00;
                    tmr_ff <= tmr_ff - 12'h001;
                end else begin
                    pre_ff <= pre_ff + 8'h01;
                end
            end
            case (state_ff)
                S_IDLE: begin
                    if (en_rise) begin
                        cnt_ff <= 9'h000;
                        abort_ff <= 1'b0;
                        pre_ff <= 8'h00;
                        tmr_ff <= acts_us(time_ff[TIME_DLY+3:TIME_DLY]);
                        // external mode arms, internal goes to delay
                        state_ff <= ctrl_ff[CTRL_EXT] ? S_ARM : S_DELAY;
                    end
                end
                S_ARM: begin
                    // no edge, no progress
                    if (edge_hit) begin
                        pre_ff <= 8'h00;
                        tmr_ff <= acts_us(cfg_dly_ff);
                        state_ff <= S_DELAY;
                    end
                end
                S_DELAY: begin
                    if (tmr_ff == 12'h000) begin
                        if (cfg_ext_ff && !trig_act) begin
                            state_ff <= S_ARM;
                        end else begin
                            conv_start_ff <= 1'b1;
                            state_ff <= S_CONV;
                        end
                    end
                end
                S_CONV: begin
                    if (i_conv_done) begin
                        cnt_ff <= cnt_ff + 9'h001;
                        seen_ff <= 1'b0;
                        if (out_lim) begin
                            abort_ff <= 1'b1;
                            state_ff <= S_FIN;
                        end else if (cnt_ff + 9'h001 == acts_nsamp(cfg_cnt_ff)) begin
                            state_ff <= S_FIN;
                        end else begin
                            // wait counted from conversion end
                            pre_ff <= 8'h00;
                            tmr_ff <= acts_us(cfg_wait_ff);
                            state_ff <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    if (edge_hit) begin
                        seen_ff <= 1'b1;
                    end
                    if (tmr_ff == 12'h000) begin
                        if (cfg_ext_ff && cfg_hold_ff &&
                            !((seen_ff || edge_hit) && trig_act)) begin
                            // hold-off: wait for a fresh trigger
                            pre_ff <= 8'h00;
                            tmr_ff <= 12'h000;
                            state_ff <= S_ARM;
                        end else begin
                            // without hold-off the trigger level does not matter here
                            conv_start_ff <= 1'b1;
                            state_ff <= S_CONV;
                        end
                    end
                end
                S_FIN: begin
                    if (rep_go) begin
                        // next cycle starts as this one ends
                        cnt_ff <= 9'h000;
                        pre_ff <= 8'h00;
                        tmr_ff <= acts_us(cfg_dly_ff);
                        state_ff <= cfg_ext_ff ? S_ARM : S_DELAY;
                    end else begin
                        state_ff <= S_IDLE;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // result unit statistics
    // ------------------------------------------------------------
    // min, max and sum track every sample whatever the select
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            min_ff <= 10'h3FF;
            max_ff <= 10'h000;
            last_ff <= 10'h000;
            sum_ff <= 18'h00000;
        end else if (cyc_start) begin
            min_ff <= 10'h3FF;
            max_ff <= 10'h000;
            sum_ff <= 18'h00000;
        end else if (state_ff == S_CONV && i_conv_done) begin
            last_ff <= i_conv_data;
            sum_ff <= sum_ff + {8'h00, i_conv_data};
            if (i_conv_data < min_ff) begin
                min_ff <= i_conv_data;
            end
            if (i_conv_data > max_ff) begin
                max_ff <= i_conv_data;
            end
        end
    end

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    // copied once per cycle so reads never see a half result
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < 4; i++) begin
                res_ff[i] <= 11'h000;
            end
        end else if (state_ff == S_FIN) begin
            res_ff[SEL_LAST] <= {1'b0, last_ff};
            res_ff[SEL_AVG] <= acts_avg(sum_ff, cfg_cnt_ff);
            res_ff[SEL_MAX] <= {1'b0, max_ff};
            res_ff[SEL_MIN] <= {1'b0, min_ff};
        end
    end

    // ------------------------------------------------------------
    // status and interrupt pin
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            int_n_ff <= 1'b1;
        end else if (state_ff == S_IDLE && en_rise) begin
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
            int_n_ff <= 1'b1;
        end else if (state_ff == S_FIN && !rep_go) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            int_n_ff <= !ctrl_ff[CTRL_IEN];
        end else if (!ctrl_ff[CTRL_EN]) begin
            // clearing enable releases the pin
            int_n_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_awready = aw_rdy_ff;
    assign o_wready = w_rdy_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_arready = ar_rdy_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;
    assign o_conv_start = conv_start_ff;
    assign o_int_n = int_n_ff;
    assign o_busy = busy_ff;
endmodule : acts_top
`default_nettype wire

// ==== hw/acts_pkg.sv ====
// How it works
// - results kept as 11-bit, accumulator 18-bit
// - results copied only at cycle end
// - sample count field gives 1 to 256
// - average, max, min and raw last sample
// - cycle ends after copy, busy clears
// - enable 0-to-1 starts a cycle
// - configuration latched until cycle ends
// - done status, interrupt low if unmasked
// - min, max, average always computed
// - select bits pick the result read
// - single sample gives equal results
// - select bits frozen while busy
// - trigger pin edge, rising or falling
// - configure, then enable arms for trigger
// - armed without trigger waits forever
// - delay 0-750 us, level rechecked after
// - wait timed from conversion end
// - no hold-off: samples on wait expiry
// - hold-off: trigger needed at wait end
// - out-of-limit sample ends cycle, done
// - repeat runs back-to-back, no done
// - trigger pin used when external bit set
// - internal start after each conversion
// - clearing repeat finishes current cycle
package acts_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TIME = 8'h04;
    localparam logic [7:0] REG_LIMIT = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_EXT = 1;
    localparam int CTRL_EDGE = 2;
    localparam int CTRL_HOLD = 3;
    localparam int CTRL_REP = 4;
    localparam int CTRL_CNT = 5;
    localparam int CTRL_SEL = 8;
    localparam int CTRL_IEN = 10;
    localparam int TIME_DLY = 0;
    localparam int TIME_WAIT = 8;
    localparam int LIM_LO = 0;
    localparam int LIM_HI = 16;
    localparam int RES_BUSY = 15;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TIME_RST = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RST = 32'h03FF_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_07FF;
    localparam logic [31:0] TIME_WMASK = 32'h0000_0F0F;
    localparam logic [31:0] LIMIT_WMASK = 32'h03FF_03FF;
    // result select codes
    localparam logic [1:0] SEL_LAST = 2'h0;
    localparam logic [1:0] SEL_AVG = 2'h1;
    localparam logic [1:0] SEL_MAX = 2'h2;
    localparam logic [1:0] SEL_MIN = 2'h3;
    // ------------------------------------------------------------
    // timing and bus answers
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int US_CYC = CLK_HZ / 1_000_000;
    localparam int STEP_US = 50;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sequencer states, gray in listed order
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ARM = 3'h1,
        S_DELAY = 3'h3,
        S_CONV = 3'h2,
        S_WAIT = 3'h6,
        S_FIN = 3'h7
    } acts_state_t;
endpackage : acts_pkg

// ==== dv/acts_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---
// port checker
// ---
module acts_properties (
    input wire logic i_clk, i_rstn, i_arvalid, i_rready, i_conv_done,
    input wire logic o_arready, o_rvalid, o_conv_start, o_busy, o_int_n,
    input wire logic [31:0] o_rdata
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    conv_busy_a: assert property (o_conv_start |-> o_busy) else $error("start while idle");
    start_pulse_a: assert property (o_conv_start |=> !o_conv_start) else $error("long start");
    busy_end_a: assert property ($fell(o_busy) |-> $past(i_conv_done, 2)) else $error("early end");
    int_end_a: assert property ($fell(o_int_n) |-> $fell(o_busy)) else $error("stray irq");
    int_clear_a: assert property ($rose(o_busy) |-> o_int_n) else $error("irq kept");
    read_lat_a: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("slow read");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=> $stable(o_rdata)) else $error("rdata moved");
    one_read_a: assert property (o_rvalid |-> !o_arready) else $error("two reads");
    cover property ($fell(o_int_n));
    cover property (o_conv_start);
    cover property ($fell(o_busy));
endmodule : acts_properties
bind acts_top acts_properties acts_properties_i (.*);
`default_nettype wire

// ==== dv/acts_conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// converter stand-in; data inverted outside done so stale values never match
module acts_conv_model (
    input wire logic i_clk, i_rstn, i_start,
    input wire logic [9:0] i_val,
    output logic o_done,
    output logic [9:0] o_data
);
    logic [1:0] cnt_ff; // cycles of conversion left
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_ff <= 2'h0;
            o_done <= 1'b0;
        end else begin
            cnt_ff <= i_start ? 2'h3 : (cnt_ff != 2'h0 ? cnt_ff - 2'h1 : 2'h0);
            o_done <= (cnt_ff == 2'h1);
        end
    end
    assign o_data = o_done ? i_val : ~i_val;
endmodule : acts_conv_model
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import acts_pkg::*;
    logic i_clk = 0, i_rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, pin = 0;
    logic awr, wrr, arr, bv, rv, st, irq_n, busy, done;
    logic [7:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, d, rdata;
    logic [1:0] bresp, rresp;
    logic [9:0] val = 0, cdata;
    logic [9:0] tab [8] = '{100, 300, 200, 400, 600, 10, 20, 30}; // sample values in order
    int n_mismatch = 0, tests_run = 0, k = 0;
    always #10 i_clk = ~i_clk;
    // next sample value, counted per start pulse
    always @(posedge i_clk) if (st) begin val <= tab[k]; k <= k + 1; end
    acts_top #(.P_STEP_US(1)) acts_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(aw), .i_awvalid(awv),
        .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrr), .o_bresp(bresp),
        .o_bvalid(bv), .i_bready(bre), .i_araddr(ar), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rv), .i_rready(rre), .o_conv_start(st), .i_conv_done(done),
        .i_conv_data(cdata), .i_trigger_pin(pin), .o_int_n(irq_n), .o_busy(busy));
    acts_conv_model acts_conv_model_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(st), .i_val(val),
        .o_done(done), .o_data(cdata));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, g, e); end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        aw <= a; wd <= v; awv <= 1; wv <= 1; bre <= 1;
        do @(posedge i_clk) begin if (awr) awv <= 0; if (wrr) wv <= 0; end while (!bv);
        bre <= 0; chk(bresp, er); @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        ar <= a; arv <= 1; rre <= 1;
        do @(posedge i_clk) if (arr) arv <= 0; while (!rv);
        rre <= 0; d = rdata; chk(rresp, er); @(posedge i_clk);
    endtask : rd
    task automatic go(input logic [31:0] c);
        k = 0; wr(REG_CTRL, c, 0); wr(REG_CTRL, c | 1, 0);
    endtask : go
    task automatic fin;
        int n = 0;
        repeat (3) @(posedge i_clk);
        while (busy !== 1'b0 && n < 5000) begin @(posedge i_clk); n++; end
        chk(busy, 0);
    endtask : fin
    // step through all four result selections
    task automatic chk4(input logic [31:0] c, input logic [10:0] e [4]);
        for (int s = 0; s < 4; s++) begin wr(REG_CTRL, c | (s << 8), 0); rd(REG_RESULT, 0); chk(d[10:0], e[s]); end
    endtask : chk4
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    initial begin #1000000; n_mismatch++; stop_test; end
    initial begin
        repeat (2) @(posedge i_clk);
        i_rstn <= 1;
        @(posedge i_clk);
        rd(REG_LIMIT, RESP_OKAY); chk(d, LIMIT_RST);
        rd(8'h14, RESP_SLVERR); chk(d, 0);
        wr(REG_TIME, 32'h0100, RESP_OKAY);
        go(32'h0420); fin; chk(irq_n, 0); chk(k, 4);
        chk4(32'h0420, '{400, 250, 400, 100});
        go(32'h0400); fin; chk4(32'h0400, '{100, 100, 100, 100});
        wr(REG_LIMIT, 32'h015E_0032, RESP_OKAY);
        go(32'h0440); fin; chk(k, 4); chk(irq_n, 0);
        // repeat of single samples; fourth sample breaks the high limit and ends the run
        go(32'h0010); fin; chk(k, 4); chk(irq_n, 1);
        rd(REG_STATUS, RESP_OKAY); chk(d, 32'h0000_0006);
        go(32'h0406); repeat (200) @(posedge i_clk); chk(busy, 1); chk(k, 0);
        // select bits must not move while the armed cycle is busy
        wr(REG_CTRL, 32'h0000_0607, RESP_OKAY); rd(REG_CTRL, RESP_OKAY); chk(d, 32'h0000_0407);
        pin <= 1; fin; chk(k, 1);
        stop_test;
    end
endmodule : tb_top
`default_nettype wire
